// ---- inc/eelb_pkg.sv ----
package eelb_pkg;

  // ==========================================================
  // Log geometry
  localparam int LOG_SECTORS = 64;
  localparam int SECTOR_BYTES = 512;
  localparam int ENTRY_SLOTS = 4;
  localparam int ENTRY_BYTES = 124;
  localparam int REC_BYTES = 18;
  localparam int HIST_RECS = 5;
  localparam int REC_W = REC_BYTES * 8;
  localparam int HIST_W = HIST_RECS * REC_W;
  localparam int MAX_ENTRIES = 255;
  localparam int MEM_DEPTH = 256 * ENTRY_BYTES;
  localparam int MEM_AW = 15;

  // ==========================================================
  // Byte positions within a sector and within an entry
  localparam logic [8:0] POS_VERSION = 9'h000;
  localparam logic [8:0] POS_IDX_LO = 9'h002;
  localparam logic [8:0] POS_ENT_FIRST = 9'h004;
  localparam logic [8:0] POS_ENT_LAST = 9'h1f3;
  localparam logic [8:0] POS_CNT_LO = 9'h1f4;
  localparam logic [8:0] POS_CNT_HI = 9'h1f5;
  localparam logic [8:0] POS_CSUM = 9'h1ff;
  localparam logic [8:0] ENT_HIST_END = 9'h05a;
  localparam logic [8:0] ENT_ERR_REG = 9'h05b;
  localparam logic [8:0] ENT_LAST = 9'h07b;
  localparam logic [6:0] OFF_LAST = 7'h7b;
  localparam logic [7:0] LAST_ENTRY = 8'hfe;

  // ==========================================================
  // Fixed byte values and values after reset
  localparam logic [7:0] LOG_VERSION = 8'h01;
  localparam logic [7:0] VENDOR_FILL = 8'hff;
  localparam logic [7:0] SOFT_RESET_CODE = 8'h00;
  localparam logic [7:0] RST_BYTE = 8'h00;
  localparam logic [15:0] RST_WORD = 16'h0000;
  localparam logic [15:0] CNT_MAX = 16'hffff;

  // ==========================================================
  // Taskfile register selects
  localparam logic [2:0] TF_DEVCTL = 3'h0;
  localparam logic [2:0] TF_FEAT = 3'h1;
  localparam logic [2:0] TF_SECCNT = 3'h2;
  localparam logic [2:0] TF_LBALO = 3'h3;
  localparam logic [2:0] TF_LBAMID = 3'h4;
  localparam logic [2:0] TF_LBAHI = 3'h5;
  localparam logic [2:0] TF_DEVHEAD = 3'h6;

  // ==========================================================
  // Millisecond timebase
  localparam int CLK_PERIOD_NS = 25;
  localparam int MS_IN_NS = 1000000;
  localparam int MS_CYCLES = MS_IN_NS / CLK_PERIOD_NS;
  localparam int MS_DIV_W = 16;

  typedef enum logic [1:0] {ST_IDLE, ST_WRITE, ST_RDADDR, ST_RDDATA} eelb_state_type;

endpackage

// ---- rtl/eelb_mem.sv ----
module eelb_mem
  import eelb_pkg::*;
(
  input wire logic clock,
  input wire logic clkEn,
  input wire logic wrEn,
  input wire logic [MEM_AW-1:0] addr,
  input wire logic [7:0] wrData,
  output logic [7:0] rdData
);

  // ==========================================================
  // Byte-wide entry store with registered read data.
  // Contents are undefined at power-up; the reader masks unwritten entries.
  logic [7:0] mem [MEM_DEPTH];

  always_ff @(posedge clock) begin
    if (clkEn) begin
      if (wrEn) begin
        mem[addr] <= wrData;
      end
      rdData <= mem[addr];
    end
  end

endmodule

// ---- rtl/eelb_core.sv ----
// How it works
// - Log is 64 sectors, read from sector zero.
// - Media and mechanism failures create an entry, unless one is being written or waits.
// - Rejected commands never create an entry.
// - All address modes share one log.
// - Sector zero header: version, index, count, checksum.
// - Four 124-byte entries per sector at fixed places.
// - Version byte always reads 01h.
// - Index names newest entry, zero when empty.
// - Entries wrap circularly back to sector zero.
// - Never written entries read as zeros.
// - Five command records then error description.
// - Record five is failing command, oldest first.
// - Missing history records are zero filled.
// - Command records carry fill byte and timestamp.
// - Records capture taskfile when command is written.
// - Low byte newest write, high byte previous.
// - Millisecond timestamp since power-on, wraps.
// - Description byte one holds error register.
module eelb_core
  import eelb_pkg::*;
#(
  parameter int MsCycles = MS_CYCLES
)
(
  input wire logic clock,
  input wire logic rst_n,
  input wire logic clkEn,
  input wire logic tfWrEn,
  input wire logic [2:0] tfSel,
  input wire logic [7:0] tfData,
  input wire logic cmdWrEn,
  input wire logic [7:0] cmdCode,
  input wire logic softRst,
  input wire logic cmdDone,
  input wire logic cmdMediaErr,
  input wire logic cmdRejected,
  input wire logic [7:0] errReg,
  input wire logic rdStart,
  input wire logic [5:0] rdSector,
  output logic rdBusy,
  output logic rdValid,
  output logic [7:0] rdData,
  output logic rdLast
);

  default clocking logCk @(posedge clock iff clkEn);
  endclocking
  default disable iff (!rst_n);

  function automatic logic [MEM_AW-1:0] entAddr(input logic [7:0] e, input logic [6:0] o);
    return MEM_AW'({7'h00, e} * MEM_AW'(ENTRY_BYTES) + {8'h00, o});
  endfunction

  // ==========================================================
  // Taskfile shadow and command history
  logic [7:0] devCtl_q, devCtl_d, devHead_q, devHead_d;
  logic [15:0] feat_q, feat_d, secCnt_q, secCnt_d, lbaLo_q, lbaLo_d;
  logic [15:0] lbaMid_q, lbaMid_d, lbaHi_q, lbaHi_d;
  logic [HIST_W-1:0] hist_q, hist_d;
  logic [REC_W-1:0] newRec;
  logic [31:0] msCount_q, msCount_d;
  logic [MS_DIV_W-1:0] msDiv_q, msDiv_d;

  always_comb begin
    devCtl_d = devCtl_q;
    devHead_d = devHead_q;
    feat_d = feat_q;
    secCnt_d = secCnt_q;
    lbaLo_d = lbaLo_q;
    lbaMid_d = lbaMid_q;
    lbaHi_d = lbaHi_q;
    // Snapshot uses the values before any write in the same cycle.
    newRec = {msCount_q, VENDOR_FILL, softRst ? SOFT_RESET_CODE : cmdCode, devHead_q,
              lbaHi_q, lbaMid_q, lbaLo_q, secCnt_q, feat_q, devCtl_q};
    hist_d = hist_q;
    if (cmdWrEn || softRst) begin
      hist_d = {newRec, hist_q[HIST_W-1:REC_W]};
    end
    if (tfWrEn) begin
      case (tfSel)
        TF_DEVCTL: devCtl_d = tfData;
        TF_FEAT: feat_d = {feat_q[7:0], tfData};
        TF_SECCNT: secCnt_d = {secCnt_q[7:0], tfData};
        TF_LBALO: lbaLo_d = {lbaLo_q[7:0], tfData};
        TF_LBAMID: lbaMid_d = {lbaMid_q[7:0], tfData};
        TF_LBAHI: lbaHi_d = {lbaHi_q[7:0], tfData};
        TF_DEVHEAD: devHead_d = tfData;
        default: devCtl_d = devCtl_q;
      endcase
    end
    // Free-running from reset; the 32-bit count simply wraps.
    msDiv_d = msDiv_q + 1'b1;
    msCount_d = msCount_q;
    if (msDiv_q == MS_DIV_W'(MsCycles - 1)) begin
      msDiv_d = '0;
      msCount_d = msCount_q + 1'b1;
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      devCtl_q <= RST_BYTE;
      devHead_q <= RST_BYTE;
      feat_q <= RST_WORD;
      secCnt_q <= RST_WORD;
      lbaLo_q <= RST_WORD;
      lbaMid_q <= RST_WORD;
      lbaHi_q <= RST_WORD;
      hist_q <= '0;
      msDiv_q <= '0;
      msCount_q <= '0;
    end else if (clkEn) begin
      devCtl_q <= devCtl_d;
      devHead_q <= devHead_d;
      feat_q <= feat_d;
      secCnt_q <= secCnt_d;
      lbaLo_q <= lbaLo_d;
      lbaMid_q <= lbaMid_d;
      lbaHi_q <= lbaHi_d;
      hist_q <= hist_d;
      msDiv_q <= msDiv_d;
      msCount_q <= msCount_d;
    end
  end

  cmd_byte_a: assert property (cmdWrEn && !softRst |=> hist_q[679:672] == $past(cmdCode));
  ms_tick_a: assert property (msDiv_q == MS_DIV_W'(MsCycles - 1)
    |=> msCount_q == $past(msCount_q) + 32'h1 && msDiv_q == '0);

  // ==========================================================
  // Entry writer and sector reader
  eelb_state_type state_q, state_d;
  logic [8:0] cnt_q, cnt_d;
  logic [5:0] sector_q, sector_d;
  logic [1:0] slot_q, slot_d;
  logic [6:0] off_q, off_d;
  logic [7:0] sum_q, sum_d, wrPtr_q, wrPtr_d, written_q, written_d, idx_q, idx_d;
  logic [15:0] errCnt_q, errCnt_d;
  logic pend_q, pend_d;
  logic [HIST_W-1:0] snap_q, snap_d;
  logic [7:0] errLatch_q, errLatch_d, rdData_q, rdData_d, outByte, memRd, memWd;
  logic rdValid_d, rdLast_d, memWe, logEv, logAccept, inEntry;
  logic [MEM_AW-1:0] memAddr;

  // Only media or mechanism failures qualify, whatever the addressing mode.
  assign logEv = cmdDone && cmdMediaErr && !cmdRejected;
  // An error completing while an entry is being written, or while one waits, is dropped.
  assign logAccept = logEv && state_q != ST_WRITE && !pend_q;
  assign rdBusy = state_q != ST_IDLE || pend_q;
  assign inEntry = cnt_q >= POS_ENT_FIRST && cnt_q <= POS_ENT_LAST;

  always_comb begin
    memWd = RST_BYTE;
    if (cnt_q < ENT_HIST_END) begin
      memWd = snap_q[cnt_q * 8 +: 8];
    end else if (cnt_q == ENT_ERR_REG) begin
      memWd = errLatch_q;
    end
    outByte = RST_BYTE;
    if (inEntry) begin
      outByte = ({sector_q, slot_q} < written_q) ? memRd : RST_BYTE;
    end else if (cnt_q == POS_CSUM) begin
      outByte = 8'(-sum_q);
    end else if (sector_q == '0) begin
      case (cnt_q)
        POS_VERSION: outByte = LOG_VERSION;
        POS_IDX_LO: outByte = idx_q;
        POS_CNT_LO: outByte = errCnt_q[7:0];
        POS_CNT_HI: outByte = errCnt_q[15:8];
        default: outByte = RST_BYTE;
      endcase
    end
  end

  always_comb begin
    state_d = state_q;
    cnt_d = cnt_q;
    sector_d = sector_q;
    slot_d = slot_q;
    off_d = off_q;
    sum_d = sum_q;
    wrPtr_d = wrPtr_q;
    written_d = written_q;
    idx_d = idx_q;
    errCnt_d = errCnt_q;
    pend_d = pend_q;
    snap_d = snap_q;
    errLatch_d = errLatch_q;
    rdData_d = rdData_q;
    rdValid_d = 1'b0;
    rdLast_d = 1'b0;
    memWe = 1'b0;
    memAddr = entAddr({sector_q, slot_q}, off_q);
    if (logAccept) begin
      pend_d = 1'b1;
      snap_d = hist_q;
      errLatch_d = errReg;
    end
    case (state_q)
      ST_IDLE: begin
        if (pend_q) begin
          state_d = ST_WRITE;
          cnt_d = '0;
          pend_d = 1'b0;
        end else if (rdStart) begin
          state_d = ST_RDADDR;
          sector_d = rdSector;
          cnt_d = '0;
          slot_d = '0;
          off_d = '0;
          sum_d = '0;
        end
      end
      ST_WRITE: begin
        memWe = 1'b1;
        memAddr = entAddr(wrPtr_q, cnt_q[6:0]);
        cnt_d = cnt_q + 1'b1;
        if (cnt_q == ENT_LAST) begin
          state_d = ST_IDLE;
          idx_d = wrPtr_q + 1'b1;
          wrPtr_d = (wrPtr_q == LAST_ENTRY) ? '0 : wrPtr_q + 1'b1;
          written_d = (written_q == 8'(MAX_ENTRIES)) ? written_q : written_q + 1'b1;
          errCnt_d = (errCnt_q == CNT_MAX) ? errCnt_q : errCnt_q + 1'b1;
        end
      end
      ST_RDADDR: begin
        state_d = ST_RDDATA;
      end
      ST_RDDATA: begin
        rdData_d = outByte;
        rdValid_d = 1'b1;
        rdLast_d = cnt_q == POS_CSUM;
        sum_d = sum_q + outByte;
        cnt_d = cnt_q + 1'b1;
        state_d = (cnt_q == POS_CSUM) ? ST_IDLE : ST_RDADDR;
        if (inEntry) begin
          off_d = (off_q == OFF_LAST) ? '0 : off_q + 1'b1;
          slot_d = (off_q == OFF_LAST) ? slot_q + 1'b1 : slot_q;
        end
      end
      default: state_d = ST_IDLE;
    endcase
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      state_q <= ST_IDLE;
      cnt_q <= '0;
      sector_q <= '0;
      slot_q <= '0;
      off_q <= '0;
      sum_q <= RST_BYTE;
      wrPtr_q <= RST_BYTE;
      written_q <= RST_BYTE;
      idx_q <= RST_BYTE;
      errCnt_q <= RST_WORD;
      pend_q <= 1'b0;
      snap_q <= '0;
      errLatch_q <= RST_BYTE;
      rdData_q <= RST_BYTE;
      rdValid <= 1'b0;
      rdLast <= 1'b0;
    end else if (clkEn) begin
      state_q <= state_d;
      cnt_q <= cnt_d;
      sector_q <= sector_d;
      slot_q <= slot_d;
      off_q <= off_d;
      sum_q <= sum_d;
      wrPtr_q <= wrPtr_d;
      written_q <= written_d;
      idx_q <= idx_d;
      errCnt_q <= errCnt_d;
      pend_q <= pend_d;
      snap_q <= snap_d;
      errLatch_q <= errLatch_d;
      rdData_q <= rdData_d;
      rdValid <= rdValid_d;
      rdLast <= rdLast_d;
    end
  end

  assign rdData = rdData_q;

  eelb_mem entryStore (
    .clock(clock),
    .clkEn(clkEn),
    .wrEn(memWe),
    .addr(memAddr),
    .wrData(memWd),
    .rdData(memRd)
  );

  // ==========================================================
  // Checking helpers and assertions
  logic [8:0] outPos_q;
  logic [5:0] outSec_q;
  logic outZero_q;
  logic [7:0] chk_q;

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      outPos_q <= '0;
      outSec_q <= '0;
      outZero_q <= 1'b0;
      chk_q <= RST_BYTE;
    end else if (clkEn) begin
      if (state_q == ST_RDDATA) begin
        outPos_q <= cnt_q;
        outSec_q <= sector_q;
        outZero_q <= inEntry && {sector_q, slot_q} >= written_q;
      end
      if (state_q == ST_IDLE && rdStart && !pend_q) begin
        chk_q <= RST_BYTE;
      end else if (rdValid) begin
        chk_q <= chk_q + rdData;
      end
    end
  end

  sequence entryWrite;
    (state_q == ST_WRITE) [*8];
  endsequence

  sequence readStep;
    state_q == ST_RDADDR ##1 state_q == ST_RDDATA ##1 rdValid;
  endsequence

  media_log_a: assert property (logEv && state_q == ST_IDLE && !pend_q && !rdStart
    |=> state_q == ST_IDLE && pend_q ##1 entryWrite);
  reject_skip_a: assert property (cmdDone && cmdRejected && state_q == ST_IDLE && !pend_q
    |=> !pend_q);
  read_pace_a: assert property (state_q == ST_IDLE && rdStart && !pend_q
    |=> readStep);
  last_byte_a: assert property (rdValid && rdLast |-> outPos_q == POS_CSUM);
  version_byte_a: assert property (rdValid && outSec_q == '0 && outPos_q == POS_VERSION
    |-> rdData == LOG_VERSION);
  empty_index_a: assert property (written_q == '0 |-> idx_q == '0);
  entry_wrap_a: assert property (state_q == ST_WRITE && cnt_q == ENT_LAST
    && wrPtr_q == LAST_ENTRY |=> wrPtr_q == '0 && idx_q == 8'(MAX_ENTRIES));
  zero_fill_a: assert property (rdValid && outZero_q |-> rdData == '0);
  sector_sum_a: assert property (rdValid && rdLast |-> 8'(chk_q + rdData) == '0);
  error_count_a: assert property (state_q == ST_WRITE && cnt_q == ENT_LAST
    && errCnt_q != CNT_MAX |=> errCnt_q == $past(errCnt_q) + 16'h1);

endmodule

// ---- tb/eelb_host.sv ----
module eelb_host
  import eelb_pkg::*;
(
  input wire logic clock,
  input wire logic rdBusy,
  input wire logic rdValid,
  input wire logic [7:0] rdData,
  input wire logic rdLast,
  output logic rdStart,
  output logic [5:0] rdSector
);
  timeunit 1ns;
  timeprecision 1ps;

  // ==========================================================
  // Sector reader
  logic [7:0] secBuf [SECTOR_BYTES];
  int byteCnt;

  initial begin
    rdStart = 1'b0;
    rdSector = 6'h2a;
    byteCnt = 0;
  end

  // Bytes are stored strictly in arrival order, so a skipped or extra byte shifts the whole
  // image and shows up in every later compare.
  task automatic readSector(input logic [5:0] sec);
    int n;
    n = 0;
    @(posedge clock);
    while (rdBusy !== 1'b0 && n < 2000) begin
      @(posedge clock);
      n++;
    end
    rdStart <= 1'b1;
    rdSector <= sec;
    @(posedge clock);
    rdStart <= 1'b0;
    // The select is meaningless once taken, so it is scrambled rather than held.
    rdSector <= ~sec;
    byteCnt = 0;
    n = 0;
    while (n < 1200) begin
      @(posedge clock);
      n++;
      if (rdValid === 1'b1) begin
        if (byteCnt < SECTOR_BYTES) begin
          secBuf[byteCnt] = rdData;
        end
        byteCnt++;
        if (rdLast === 1'b1) begin
          break;
        end
      end
    end
  endtask
endmodule

// ---- tb/test_extended_error_log_builder.sv ----
module test_extended_error_log_builder
  import eelb_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  // ==========================================================
  // Signals and instances
  logic clock, rst_n, clkEn, tfWrEn, cmdWrEn, softRst, cmdDone, cmdMediaErr, cmdRejected;
  logic [2:0] tfSel;
  logic [7:0] tfData, cmdCode, errReg, rdData;
  logic rdStart, rdBusy, rdValid, rdLast;
  logic [5:0] rdSector;
  int error_cnt, total_checks, cycles;

  typedef struct {
    logic [7:0] cmd;
    logic media;
    logic rej;
    logic [7:0] idx;
  } eelb_row_type;
  eelb_row_type rows [5] = '{
    '{8'h25, 1'b1, 1'b0, 8'h01},
    '{8'h35, 1'b1, 1'b1, 8'h01},
    '{8'hc8, 1'b0, 1'b0, 8'h01},
    '{8'hca, 1'b1, 1'b0, 8'h02},
    '{8'h24, 1'b1, 1'b0, 8'h03}
  };

  eelb_core #(.MsCycles(4)) dut (.clock(clock), .rst_n(rst_n), .clkEn(clkEn), .tfWrEn(tfWrEn),
    .tfSel(tfSel), .tfData(tfData), .cmdWrEn(cmdWrEn), .cmdCode(cmdCode), .softRst(softRst),
    .cmdDone(cmdDone), .cmdMediaErr(cmdMediaErr), .cmdRejected(cmdRejected), .errReg(errReg),
    .rdStart(rdStart), .rdSector(rdSector), .rdBusy(rdBusy), .rdValid(rdValid),
    .rdData(rdData), .rdLast(rdLast));

  eelb_host host (.clock(clock), .rdBusy(rdBusy), .rdValid(rdValid), .rdData(rdData),
    .rdLast(rdLast), .rdStart(rdStart), .rdSector(rdSector));

  initial begin
    clock = 1'b0;
    forever #12.5 clock = ~clock;
  end

  // ==========================================================
  // Tasks
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  task automatic chkByte(input logic [7:0] got, input logic [7:0] exp);
    total_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic tfWrite(input logic [2:0] sel, input logic [7:0] val);
    @(posedge clock);
    tfWrEn <= 1'b1;
    tfSel <= sel;
    tfData <= val;
    @(posedge clock);
    tfWrEn <= 1'b0;
  endtask

  // Issues one command and completes it; waits out the entry write that may follow.
  task automatic logErr(input logic [7:0] cmd, input logic media, input logic rej);
    int n;
    @(posedge clock);
    cmdWrEn <= 1'b1;
    cmdCode <= cmd;
    @(posedge clock);
    cmdWrEn <= 1'b0;
    cmdDone <= 1'b1;
    cmdMediaErr <= media;
    cmdRejected <= rej;
    errReg <= cmd ^ 8'h3c;
    @(posedge clock);
    cmdDone <= 1'b0;
    @(posedge clock);
    n = 0;
    while (rdBusy !== 1'b0 && n < 300) begin
      @(posedge clock);
      n++;
    end
    chkByte({7'h00, n < 300}, 8'h01);
  endtask

  task automatic readSec(input logic [5:0] sec);
    logic [7:0] sum;
    sum = 8'h00;
    host.readSector(sec);
    chkByte({7'h00, host.byteCnt == SECTOR_BYTES}, 8'h01);
    for (int b = 0; b < SECTOR_BYTES; b++) begin
      sum = sum + host.secBuf[b];
    end
    chkByte(sum, 8'h00);
  endtask

  task automatic chkBlank();
    readSec(6'h00);
    for (int b = 0; b < SECTOR_BYTES; b++) begin
      chkByte(host.secBuf[b], (b == 0) ? LOG_VERSION : (b == 511) ? 8'hff : 8'h00);
    end
  endtask

  function automatic logic [7:0] eb(input int slot, input int off);
    return host.secBuf[4 + 124 * slot + off];
  endfunction

  function automatic logic [31:0] ts(input int slot, input int rec);
    return {eb(slot, rec + 17), eb(slot, rec + 16), eb(slot, rec + 15), eb(slot, rec + 14)};
  endfunction

  // ==========================================================
  // Timeout
  always @(posedge clock) begin
    cycles++;
    if (cycles == 80000) begin
      error_cnt++;
      $display("Error at %0t: timeout %h %h", $time, cycles, 80000);
      report_and_stop();
    end
  end

  // ==========================================================
  // Main sequence
  initial begin
    int slot, k, rec;
    {rst_n, tfWrEn, cmdWrEn, softRst, cmdDone, cmdMediaErr, cmdRejected} = 7'h00;
    clkEn = 1'b1;
    tfSel = 3'h0;
    {tfData, cmdCode, errReg} = 24'h000000;
    {error_cnt, total_checks, cycles} = {32'h0, 32'h0, 32'h0};
    repeat (5) @(posedge clock);
    rst_n <= 1'b1;
    chkBlank();
    $display("empty log test done");
    tfWrite(TF_DEVCTL, 8'h08);
    tfWrite(TF_DEVHEAD, 8'he0);
    for (int i = 0; i < 5; i++) begin
      tfWrite(TF_FEAT, rows[i].cmd + 8'h01);
      tfWrite(TF_FEAT, rows[i].cmd + 8'h02);
      logErr(rows[i].cmd, rows[i].media, rows[i].rej);
      readSec(6'h00);
      chkByte(host.secBuf[2], rows[i].idx);
      chkByte(host.secBuf[500], rows[i].idx);
      if (rows[i].media === 1'b1 && rows[i].rej === 1'b0) begin
        slot = int'(rows[i].idx) - 1;
        chkByte(eb(slot, 72), 8'h08);
        chkByte(eb(slot, 73), rows[i].cmd + 8'h02);
        chkByte(eb(slot, 74), rows[i].cmd + 8'h01);
        chkByte(eb(slot, 83), 8'he0);
        chkByte(eb(slot, 91), rows[i].cmd ^ 8'h3c);
        for (int j = 0; j < 5; j++) begin
          k = i - j;
          rec = 18 * (4 - j);
          chkByte(eb(slot, rec + 12), (k >= 0) ? rows[k].cmd : 8'h00);
          chkByte(eb(slot, rec + 13), (k >= 0) ? VENDOR_FILL : 8'h00);
        end
        if (i > 0) begin
          chkByte({7'h00, ts(slot, 72) > ts(slot, 54)}, 8'h01);
        end
      end
    end
    $display("entry content test done");
    for (int i = 0; i < 252; i++) begin
      logErr(8'h42, 1'b1, 1'b0);
    end
    readSec(6'h00);
    chkByte(host.secBuf[2], 8'hff);
    chkByte(host.secBuf[3], 8'h00);
    readSec(6'h3f);
    chkByte(eb(2, 84), 8'h42);
    chkByte(eb(3, 84), 8'h00);
    logErr(8'h61, 1'b1, 1'b0);
    readSec(6'h00);
    chkByte(host.secBuf[2], 8'h01);
    chkByte(eb(0, 84), 8'h61);
    chkByte(host.secBuf[500], 8'h00);
    chkByte(host.secBuf[501], 8'h01);
    $display("wrap test done");
    @(posedge clock);
    softRst <= 1'b1;
    @(posedge clock);
    softRst <= 1'b0;
    logErr(8'h70, 1'b1, 1'b0);
    readSec(6'h00);
    chkByte(host.secBuf[2], 8'h02);
    chkByte(eb(1, 66), SOFT_RESET_CODE);
    chkByte(eb(1, 67), VENDOR_FILL);
    chkByte(eb(1, 84), 8'h70);
    $display("soft reset test done");
    @(posedge clock);
    rst_n <= 1'b0;
    repeat (5) @(posedge clock);
    rst_n <= 1'b1;
    chkBlank();
    $display("reset test done");
    report_and_stop();
  end
endmodule
